// [common/cpm_consts.svh]
// named constants for the control and program move decode block
`ifndef CPM_CONSTS_SVH
`define CPM_CONSTS_SVH
// ==========================================================
// opcode fields
`define CPM_F_HI       23:16
`define CPM_F_W        15
`define CPM_F_EA       14
`define CPM_F_MID      13:8
`define CPM_F_IMM      15:8
`define CPM_F_T3       7:5
`define CPM_F_T2       7:6
`define CPM_F_MEMB     7
`define CPM_F_SPC      6
`define CPM_F_ONE      5
`define CPM_F_CR       4:0
`define CPM_F_PMR      5:0
`define CPM_OP_CTLREG  8'h04
`define CPM_OP_CTLMEM  8'h05
`define CPM_OP_PMEM    8'h07
`define CPM_TAIL_CTL   3'h5
`define CPM_TAIL_PMEA  2'h2
`define CPM_TAIL_PMAA  2'h0
`define CPM_EA_ABS     6'h30
`define CPM_EA_IMM     6'h34
// ==========================================================
// control register codes
`define CPM_CTL_FLAG   5
`define CPM_CR_GRP     4:3
`define CPM_CR_MIDX    2:0
`define CPM_CR_MODGRP  2'h0
`define CPM_CR_VBA     5'h08
`define CPM_CR_SR      5'h19
`define CPM_CR_OMR     5'h1A
`define CPM_CR_SP      5'h1B
`define CPM_CR_SSH     5'h1C
`define CPM_CR_SSL     5'h1D
`define CPM_CR_LA      5'h1E
`define CPM_CR_LC      5'h1F
`define CPM_SEL_SSH    {1'b1, `CPM_CR_SSH}
`define CPM_SEL_SR     {1'b1, `CPM_CR_SR}
`define CPM_CCR_S      7
`define CPM_CCR_L      6
`define CPM_CCR        7:0
`define CPM_CCR_REST   5:0
`define CPM_RST16      16'h0000
`define CPM_ONE16      16'h0001
`define CPM_STK_AW     4
`define CPM_STK_DEPTH  16
// ==========================================================
// register map (byte addresses)
`define CPM_A_OPCODE   8'h00
`define CPM_A_PC       8'h04
`define CPM_A_STAT     8'h08
`define CPM_A_SR       8'h0C
`define CPM_A_SP       8'h10
`define CPM_A_RES      8'h14
`endif

// [common/cpm_pkg.sv]
// types shared by the control and program move decode block
package cpm_pkg;
  // ========================================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEC  = 3'b001,
    ST_EXT  = 3'b010,
    ST_EA   = 3'b011,
    ST_SRC  = 3'b100,
    ST_MEM  = 3'b101
  } cpm_state_t;
  // memory spaces on the data bus
  typedef enum logic [1:0] {
    SPC_X = 2'b00,
    SPC_Y = 2'b01,
    SPC_P = 2'b10
  } cpm_space_t;
endpackage

// [sim/cpm_move_top_tb.sv]
// self-checking bench for the control and program move block
`timescale 1ns/1ps
`default_nettype none
module cpm_move_top_tb;
  // ==================================================
  // bench state
  logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
  logic        ack = 0, grow = 0, lim = 0, err, prdy, perr, mreq;
  logic        mwr, gwe, c_wr, estb, bsy;
  logic [7:0]  padr = 8'h00;
  logic [31:0] pwd = 32'h0, rd, prd;
  logic [1:0]  msp, c_sp;
  logic [5:0]  gsel, c_gs, efld, c_ef;
  logic [15:0] mdat = 16'h0, gdat = 16'h0, madr, mwd, gwd, sr, sp;
  logic [15:0] c_ad, c_wd, c_gd, mrd;
  int          miscompares = 0, checked = 0, cyc = 0;
  // ==================================================
  // design
  cpm_move_top i_dut (
    .I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(padr), .I_PWDATA(pwd),
    .O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(perr),
    .O_MEM_REQ(mreq), .O_MEM_WR(mwr), .O_MEM_SPACE(msp),
    .O_MEM_ADDR(madr), .O_MEM_WDATA(mwd), .I_MEM_RDATA(mrd),
    .I_MEM_ACK(ack), .O_EA_STROBE(estb), .O_EA_FIELD(efld),
    .I_EA_ADDR(16'h1234), .O_GREG_SEL(gsel), .O_GREG_WE(gwe),
    .O_GREG_WDATA(gwd), .I_GREG_RDATA(gdat), .I_MOVE_GROWTH(grow),
    .I_MOVE_LIMIT(lim), .O_BUSY(bsy), .O_SR(sr), .O_SP(sp));
  // read data is garbage outside the ack so stale values never pass
  assign mrd = ack ? mdat : ~mdat;
  initial forever #4 clk = ~clk;
  // memory acks one cycle into a request; capture what was asked
  always @(posedge clk) begin
    ack <= mreq && !ack;
    if (ack) begin
      {c_sp, c_wr, c_ad, c_wd} <= {msp, mwr, madr, mwd};
    end
    if (estb) c_ef <= efld;
    if (gwe) begin
      {c_gs, c_gd} <= {gsel, gwd};
    end
  end
  // hang guard, far beyond the length of the whole sequence
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  // ==================================================
  // tasks
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // issue an opcode, then poll status until idle; rd keeps status
  task automatic run(input logic [23:0] op);
    logic b;
    apb(1'b1, 8'h00, {8'h00, op});
    // busy must show in the cycle after the opcode is taken
    @(negedge clk);
    b = bsy;
    rd = 32'h1;
    for (int k = 0; k < 40 && rd[0] !== 1'b0; k++) apb(1'b0, 8'h08, 0);
    chk({b, rd[0], bsy}, 3'b100);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ==================================================
  // sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // every control register code takes a short immediate
    for (int i = 0; i < 16; i++) begin
      run({8'h05, 8'h10 + 8'(i), 3'b101, 5'(i < 9 ? i : i + 16)});
      chk(rd[1], 1'b0);
      apb(1'b0, 8'h14, 32'h0);
      chk(rd, 32'h10 + i);
    end
    $display("test codes done");
    run(24'h0500BB);
    chk(sp, 16'h0000);
    run(24'h055ABC);
    chk(sp, 16'h0001);
    run(24'h0444BC);
    chk(sp, 16'h0000);
    chk({c_gs, c_gd}, {6'h04, 16'h005A});
    // status destination, then flags raised by a general source
    run(24'h0525B9);
    chk(sr, 16'h0025);
    gdat <= 16'h8001;
    grow <= 1'b1;
    lim <= 1'b1;
    run(24'h04C4BA);
    chk(sr, 16'h00E5);
    grow <= 1'b0;
    lim <= 1'b0;
    mdat <= 16'h1357;
    run(24'h05AA63);
    chk({c_sp, c_wr, c_ad}, {2'h1, 1'b0, 16'h002A});
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h1357);
    run(24'h054028);
    chk({c_sp, c_wr, c_ad, c_wd}, {2'h0, 1'b1, 32'h12340018});
    chk(c_ef, 6'h00);
    gdat <= 16'hBEEF;
    run(24'h071504);
    chk({c_sp, c_wr, c_ad, c_wd}, {2'h2, 1'b1, 32'h0015BEEF});
    // refusals: bad opcode, unmapped and read-only places
    run(24'h000000);
    chk(rd[1], 1'b1);
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, 8'h0C, 32'hFFFF);
    chk({err, sr}, {1'b1, 16'h00E5});
    $display("test moves done");
    print_verdict();
  end
endmodule
`default_nettype wire

// [verilog/cpm_ctlregs.sv]
// control register file with the system stack
`timescale 1ns/1ps
`default_nettype none
`include "cpm_consts.svh"
module cpm_ctlregs (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // read side
  input  wire logic [4:0]  i_rd_sel,
  input  wire logic        i_pop,
  output logic [15:0]      o_rd_data,
  // write side and flag updates
  input  wire logic        i_wr_en,
  input  wire logic [4:0]  i_wr_sel,
  input  wire logic [15:0] i_wr_data,
  input  wire logic        i_set_s,
  input  wire logic        i_set_l,
  // state shown outside
  output logic [15:0]      o_sr,
  output logic [15:0]      o_sp
);
  logic [15:0] mod_reg [0:7];
  logic [15:0] stk_hi  [0:`CPM_STK_DEPTH-1];
  logic [15:0] stk_lo  [0:`CPM_STK_DEPTH-1];
  logic [15:0] vba_reg, omr_reg, la_reg, lc_reg, sr_reg, sp_reg;
  logic [`CPM_STK_AW-1:0] top_idx, up_idx;

  assign top_idx = sp_reg[`CPM_STK_AW-1:0];
  assign up_idx  = top_idx + 1'b1;
  assign o_sr    = sr_reg;
  assign o_sp    = sp_reg;

  // ========================================================
  // read mux
  always_comb begin
    case (i_rd_sel)
      `CPM_CR_VBA: o_rd_data = vba_reg;
      `CPM_CR_SR:  o_rd_data = sr_reg;
      `CPM_CR_OMR: o_rd_data = omr_reg;
      `CPM_CR_SP:  o_rd_data = sp_reg;
      `CPM_CR_SSH: o_rd_data = stk_hi[top_idx];
      `CPM_CR_SSL: o_rd_data = stk_lo[top_idx];
      `CPM_CR_LA:  o_rd_data = la_reg;
      `CPM_CR_LC:  o_rd_data = lc_reg;
      default:     o_rd_data = mod_reg[i_rd_sel[`CPM_CR_MIDX]];
    endcase
  end

  // ========================================================
  // control registers; a push in the same cycle as a pop overrides the pop
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 8; i++) mod_reg[i] <= `CPM_RST16;
      {vba_reg, omr_reg, la_reg} <= {3{`CPM_RST16}};
      {lc_reg, sr_reg, sp_reg}   <= {3{`CPM_RST16}};
    end else begin
      if (i_pop) sp_reg <= sp_reg - `CPM_ONE16;
      if (i_set_s) sr_reg[`CPM_CCR_S] <= 1'b1;
      if (i_set_l) sr_reg[`CPM_CCR_L] <= 1'b1;
      if (i_wr_en) begin
        case (i_wr_sel)
          `CPM_CR_VBA: vba_reg <= i_wr_data;
          `CPM_CR_SR:  sr_reg  <= i_wr_data;
          `CPM_CR_OMR: omr_reg <= i_wr_data;
          `CPM_CR_SP:  sp_reg  <= i_wr_data;
          `CPM_CR_SSH: sp_reg  <= sp_reg + `CPM_ONE16;
          `CPM_CR_SSL: ;
          `CPM_CR_LA:  la_reg  <= i_wr_data;
          `CPM_CR_LC:  lc_reg  <= i_wr_data;
          default: mod_reg[i_wr_sel[`CPM_CR_MIDX]] <= i_wr_data;
        endcase
      end
    end
  end

  // stack storage; the high word lands one above the old top
  always_ff @(posedge i_clk) begin
    if (i_wr_en && i_wr_sel == `CPM_CR_SSH) stk_hi[up_idx] <= i_wr_data;
    if (i_wr_en && i_wr_sel == `CPM_CR_SSL) stk_lo[top_idx] <= i_wr_data;
  end
endmodule
`default_nettype wire

// [verilog/cpm_move_top.sv]
// sequencer for control register and program memory moves
//
// Summary of operation
// - control move reads or loads control registers
// - narrow set: modifiers and program controller only
// - all memory modes plus short immediate
// - stack high read: pointer drops after read
// - stack high write: pointer rises before write
// - status destination loads bits seven to zero
// - otherwise growth sets the scaling flag
// - otherwise saturation sets the limit flag
// - memory control move opcode layout
// - register to register control move layout
// - short immediate control move layout
// - five bit field picks control register
// - six bit absolute short address
// - direction bit picks read or write
// - space bit picks X or Y memory
// - program move: any register, alterable modes
// - program move keeps stack high effects
// - program move effective address layout
// - program move absolute short layout
`timescale 1ns/1ps
`default_nettype none
`include "cpm_consts.svh"
module cpm_move_top (
  // clock and reset
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RESET_N,
  // apb slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic [31:0]      O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // data and program memory bus
  output logic             O_MEM_REQ,
  output logic             O_MEM_WR,
  output logic [1:0]       O_MEM_SPACE,
  output logic [15:0]      O_MEM_ADDR,
  output logic [15:0]      O_MEM_WDATA,
  input  wire logic [15:0] I_MEM_RDATA,
  input  wire logic        I_MEM_ACK,
  // address unit
  output logic             O_EA_STROBE,
  output logic [5:0]       O_EA_FIELD,
  input  wire logic [15:0] I_EA_ADDR,
  // general register file
  output logic [5:0]       O_GREG_SEL,
  output logic             O_GREG_WE,
  output logic [15:0]      O_GREG_WDATA,
  input  wire logic [15:0] I_GREG_RDATA,
  input  wire logic        I_MOVE_GROWTH,
  input  wire logic        I_MOVE_LIMIT,
  // status
  output logic             O_BUSY,
  output logic [15:0]      O_SR,
  output logic [15:0]      O_SP
);
  // ========================================================
  // state
  cpm_pkg::cpm_state_t state_reg, state_next;
  logic [23:0] opcode_reg;
  logic [15:0] pc_reg, addr_reg, val_reg, result_reg;
  logic [1:0]  flg_reg;
  logic        illegal_reg, busy_reg;
  logic        pready_reg, pslverr_reg;
  logic [31:0] prdata_reg;
  logic        mem_req_reg, mem_wr_reg;
  logic [1:0]  mem_space_reg;
  logic [15:0] mem_addr_reg, mem_wdata_reg;
  logic        ea_strobe_reg, greg_we_reg;
  logic [5:0]  ea_field_reg, greg_sel_reg;
  logic [15:0] greg_wdata_reg;

  // decoded operation
  logic        legal, pmem, use_ea, need_ext, eimm;
  logic        src_imm, src_mem, dst_mem;
  logic [5:0]  src_sel, dst_sel;
  logic [1:0]  space;
  logic [15:0] cr_rd_data;

  cpm_opdec u_dec (
    .i_opcode   (opcode_reg),
    .o_legal    (legal),
    .o_pmem     (pmem),
    .o_use_ea   (use_ea),
    .o_need_ext (need_ext),
    .o_eimm     (eimm),
    .o_src_imm  (src_imm),
    .o_src_mem  (src_mem),
    .o_dst_mem  (dst_mem),
    .o_src_sel  (src_sel),
    .o_dst_sel  (dst_sel),
    .o_space    (space)
  );

  // ========================================================
  // apb decode; the answer comes one cycle into the access phase
  wire apb_acc  = I_PSEL && I_PENABLE;
  wire apb_fire = apb_acc && pready_reg;
  wire apb_wr   = apb_fire && I_PWRITE;
  wire hit_op   = I_PADDR == `CPM_A_OPCODE;
  wire hit_pc   = I_PADDR == `CPM_A_PC;
  wire hit_stat = I_PADDR == `CPM_A_STAT;
  wire hit_sr   = I_PADDR == `CPM_A_SR;
  wire hit_sp   = I_PADDR == `CPM_A_SP;
  wire hit_res  = I_PADDR == `CPM_A_RES;
  wire hit_ro   = hit_stat || hit_sr || hit_sp || hit_res;
  wire mapped   = hit_op || hit_pc || hit_ro;
  // an opcode written while busy is refused, not queued
  wire apb_err  = !mapped || (I_PWRITE && (hit_ro
               || (hit_op && state_reg != cpm_pkg::ST_IDLE)));
  wire start    = apb_wr && hit_op
               && state_reg == cpm_pkg::ST_IDLE;
  wire [31:0] rd_word =
      hit_op   ? {8'h00, opcode_reg} :
      hit_pc   ? {16'h0000, pc_reg} :
      hit_stat ? {27'h0000000, state_reg, illegal_reg, busy_reg} :
      hit_sr   ? {16'h0000, O_SR} :
      hit_sp   ? {16'h0000, O_SP} :
      hit_res  ? {16'h0000, result_reg} : 32'h00000000;

  // ========================================================
  // operand selection
  wire mem_done = mem_req_reg && I_MEM_ACK;
  wire src_reg  = !src_mem && !src_imm;
  wire src_ctl  = src_reg && src_sel[`CPM_CTL_FLAG];
  wire dst_ctl  = !dst_mem && dst_sel[`CPM_CTL_FLAG];
  wire dst_sr   = !dst_mem && dst_sel == `CPM_SEL_SR;
  wire in_src   = state_reg == cpm_pkg::ST_SRC;
  wire in_mem   = state_reg == cpm_pkg::ST_MEM;
  wire [15:0] src_val =
      eimm    ? val_reg :
      src_imm ? {8'h00, opcode_reg[`CPM_F_IMM]} :
      src_ctl ? cr_rd_data : I_GREG_RDATA;
  // the address of this step, before it lands in addr_reg
  wire [15:0] addr_now =
      state_reg == cpm_pkg::ST_DEC ?
        {10'h000, opcode_reg[`CPM_F_MID]} :
      state_reg == cpm_pkg::ST_EXT ? I_MEM_RDATA :
      state_reg == cpm_pkg::ST_EA  ? I_EA_ADDR : addr_reg;
  wire [1:0]  flg_now = (in_src && src_reg && !src_ctl) ?
                        {I_MOVE_GROWTH, I_MOVE_LIMIT} : flg_reg;
  // register destination written: after a read or from the source
  wire        fin     = (in_src && !dst_mem)
                     || (in_mem && mem_done && src_mem);
  wire [15:0] fin_val = in_mem ? I_MEM_RDATA : src_val;
  wire        moved   = fin || (in_mem && mem_done && dst_mem);
  wire        cr_pop  = in_src && src_ctl
                     && src_sel == `CPM_SEL_SSH;
  wire        cr_wr   = fin && dst_ctl;
  wire        set_s   = moved && !dst_sr && flg_now[1];
  wire        set_l   = moved && !dst_sr && flg_now[0];
  wire go_ext = state_reg == cpm_pkg::ST_DEC
             && state_next == cpm_pkg::ST_EXT;
  wire go_mem = state_next == cpm_pkg::ST_MEM && !in_mem;

  cpm_ctlregs u_regs (
    .i_clk     (I_CORE_CLK),
    .i_rst_n   (I_RESET_N),
    .i_rd_sel  (src_sel[`CPM_F_CR]),
    .i_pop     (cr_pop),
    .o_rd_data (cr_rd_data),
    .i_wr_en   (cr_wr),
    .i_wr_sel  (dst_sel[`CPM_F_CR]),
    .i_wr_data (fin_val),
    .i_set_s   (set_s),
    .i_set_l   (set_l),
    .o_sr      (O_SR),
    .o_sp      (O_SP)
  );

  // ========================================================
  // sequencer: decode, extension, address, source, memory
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cpm_pkg::ST_IDLE:
        if (start) state_next = cpm_pkg::ST_DEC;
      cpm_pkg::ST_DEC:
        if (!legal) state_next = cpm_pkg::ST_IDLE;
        else if (need_ext) state_next = cpm_pkg::ST_EXT;
        else if (use_ea) state_next = cpm_pkg::ST_EA;
        else if (src_mem) state_next = cpm_pkg::ST_MEM;
        else state_next = cpm_pkg::ST_SRC;
      cpm_pkg::ST_EXT:
        if (mem_done) state_next = src_mem ? cpm_pkg::ST_MEM
                                           : cpm_pkg::ST_SRC;
      cpm_pkg::ST_EA:
        state_next = src_mem ? cpm_pkg::ST_MEM : cpm_pkg::ST_SRC;
      cpm_pkg::ST_SRC:
        state_next = dst_mem ? cpm_pkg::ST_MEM : cpm_pkg::ST_IDLE;
      cpm_pkg::ST_MEM:
        if (mem_done) state_next = cpm_pkg::ST_IDLE;
      default: state_next = cpm_pkg::ST_IDLE;
    endcase
  end

  // sequencer state, command and bookkeeping registers
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESET_N) begin
      state_reg   <= cpm_pkg::ST_IDLE;
      opcode_reg  <= 24'h000000;
      {pc_reg, addr_reg} <= {2{`CPM_RST16}};
      {val_reg, result_reg} <= {2{`CPM_RST16}};
      flg_reg     <= 2'h0;
      illegal_reg <= 1'b0;
      busy_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      busy_reg  <= state_next != cpm_pkg::ST_IDLE;
      addr_reg  <= addr_now;
      if (start) opcode_reg <= I_PWDATA[23:0];
      if (apb_wr && hit_pc) pc_reg <= I_PWDATA[15:0];
      if (start) illegal_reg <= 1'b0;
      else if (state_reg == cpm_pkg::ST_DEC && !legal)
        illegal_reg <= 1'b1;
      if (state_reg == cpm_pkg::ST_EXT && eimm && mem_done)
        val_reg <= I_MEM_RDATA;
      flg_reg <= in_src ? flg_now : flg_reg;
      if (state_reg == cpm_pkg::ST_DEC) flg_reg <= 2'h0;
      if (moved) result_reg <= fin_val;
    end
  end

  // ========================================================
  // memory bus: request held until acknowledged
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESET_N) begin
      mem_req_reg   <= 1'b0;
      mem_wr_reg    <= 1'b0;
      mem_space_reg <= cpm_pkg::SPC_X;
      mem_addr_reg  <= `CPM_RST16;
      mem_wdata_reg <= `CPM_RST16;
    end else if (go_ext) begin
      mem_req_reg   <= 1'b1;
      mem_wr_reg    <= 1'b0;
      mem_space_reg <= cpm_pkg::SPC_P;
      mem_addr_reg  <= pc_reg + `CPM_ONE16;
    end else if (go_mem) begin
      mem_req_reg   <= 1'b1;
      mem_wr_reg    <= dst_mem;
      mem_space_reg <= space;
      mem_addr_reg  <= addr_now;
      mem_wdata_reg <= src_val;
    end else if (mem_done) begin
      mem_req_reg   <= 1'b0;
    end
  end

  // address unit and general register strobes
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESET_N) begin
      ea_strobe_reg  <= 1'b0;
      ea_field_reg   <= 6'h00;
      greg_we_reg    <= 1'b0;
      greg_sel_reg   <= 6'h00;
      greg_wdata_reg <= `CPM_RST16;
    end else begin
      ea_strobe_reg <= state_reg == cpm_pkg::ST_DEC
                    && state_next == cpm_pkg::ST_EA;
      if (state_reg == cpm_pkg::ST_DEC) begin
        ea_field_reg <= opcode_reg[`CPM_F_MID];
        greg_sel_reg <= src_sel;
      end
      greg_we_reg <= fin && !dst_ctl;
      if (fin) begin
        greg_sel_reg   <= dst_sel;
        greg_wdata_reg <= fin_val;
      end
    end
  end

  // apb answer; write effects above are taken on apb_fire only
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESET_N) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      pready_reg <= apb_acc && !pready_reg;
      if (apb_acc && !pready_reg) begin
        pslverr_reg <= apb_err;
        prdata_reg  <= I_PWRITE ? 32'h00000000 : rd_word;
      end
    end
  end

  assign O_PRDATA     = prdata_reg;
  assign O_PREADY     = pready_reg;
  assign O_PSLVERR    = pslverr_reg;
  assign O_MEM_REQ    = mem_req_reg;
  assign O_MEM_WR     = mem_wr_reg;
  assign O_MEM_SPACE  = mem_space_reg;
  assign O_MEM_ADDR   = mem_addr_reg;
  assign O_MEM_WDATA  = mem_wdata_reg;
  assign O_EA_STROBE  = ea_strobe_reg;
  assign O_EA_FIELD   = ea_field_reg;
  assign O_GREG_SEL   = greg_sel_reg;
  assign O_GREG_WE    = greg_we_reg;
  assign O_GREG_WDATA = greg_wdata_reg;
  assign O_BUSY       = busy_reg;

  // ========================================================
  // checks on the sequencer
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESET_N);

  a_ssh_pop_sp: assert property (cr_pop |=>
    O_SP == $past(O_SP) - `CPM_ONE16)
    else $error("stack pointer not decremented on pop");
  a_ssh_push_sp: assert property (
    cr_wr && dst_sel == `CPM_SEL_SSH |=>
    O_SP == $past(O_SP) + `CPM_ONE16)
    else $error("stack pointer not incremented on push");
  a_sr_load_ccr: assert property (cr_wr && dst_sr |=>
    O_SR[`CPM_CCR] == $past(fin_val[`CPM_CCR]))
    else $error("status byte not loaded from source");
  a_growth_scale: assert property (
    moved && !dst_sr && flg_now[1] |=> O_SR[`CPM_CCR_S])
    else $error("scaling flag not set on growth");
  a_limit_flag: assert property (
    moved && !dst_sr && flg_now[0] |=> O_SR[`CPM_CCR_L])
    else $error("limit flag not set on saturation");
  a_ccr_kept: assert property (moved && !dst_sr |=>
    O_SR[`CPM_CCR_REST] == $past(O_SR[`CPM_CCR_REST]))
    else $error("unrelated condition bits changed");
  a_bad_opcode: assert property (
    state_reg == cpm_pkg::ST_DEC && !legal |=>
    state_reg == cpm_pkg::ST_IDLE && illegal_reg && !O_MEM_REQ)
    else $error("illegal opcode not refused");
  a_ext_fetch: assert property (go_ext |=> O_MEM_REQ
    && O_MEM_SPACE == cpm_pkg::SPC_P && !O_MEM_WR
    && O_MEM_ADDR == $past(pc_reg) + `CPM_ONE16)
    else $error("extension word not fetched from pc+1");
  a_space_dir: assert property (go_mem && !pmem |=>
    O_MEM_SPACE == (opcode_reg[`CPM_F_SPC] ? cpm_pkg::SPC_Y
                                           : cpm_pkg::SPC_X)
    && O_MEM_WR == !opcode_reg[`CPM_F_W])
    else $error("memory space or direction wrong");
  a_abs_short: assert property (
    state_reg == cpm_pkg::ST_DEC && legal && !use_ea && src_mem
    |=> O_MEM_ADDR == {10'h000, opcode_reg[`CPM_F_MID]})
    else $error("absolute short address wrong");
endmodule
`default_nettype wire

// [verilog/cpm_opdec.sv]
// opcode decoder for the control and program move forms
`timescale 1ns/1ps
`default_nettype none
`include "cpm_consts.svh"
module cpm_opdec (
  // instruction word
  input  wire logic [23:0] i_opcode,
  // decoded operation
  output logic             o_legal,
  output logic             o_pmem,
  output logic             o_use_ea,
  output logic             o_need_ext,
  output logic             o_eimm,
  output logic             o_src_imm,
  output logic             o_src_mem,
  output logic             o_dst_mem,
  output logic [5:0]       o_src_sel,
  output logic [5:0]       o_dst_sel,
  output logic [1:0]       o_space
);
  // ========================================================
  // a six-bit select with the flag bit names a control register
  function automatic logic cr_ok(input logic [5:0] sel);
    cr_ok = !sel[`CPM_CTL_FLAG]
         || sel[`CPM_CR_GRP] == `CPM_CR_MODGRP
         || sel[`CPM_F_CR] == `CPM_CR_VBA
         || sel[`CPM_F_CR] >= `CPM_CR_SR;
  endfunction

  // ========================================================
  // form detection
  wire [7:0] hi       = i_opcode[`CPM_F_HI];
  wire       w        = i_opcode[`CPM_F_W];
  wire       ea       = i_opcode[`CPM_F_EA];
  wire [5:0] mode     = i_opcode[`CPM_F_MID];
  wire [5:0] crsel    = {1'b1, i_opcode[`CPM_F_CR]};
  wire       tail_ctl = i_opcode[`CPM_F_T3] == `CPM_TAIL_CTL;
  wire ctl_mem = hi == `CPM_OP_CTLMEM && !i_opcode[`CPM_F_MEMB]
              && i_opcode[`CPM_F_ONE];
  wire ctl_imm = hi == `CPM_OP_CTLMEM && tail_ctl;
  wire ctl_reg = hi == `CPM_OP_CTLREG && ea && tail_ctl;
  wire pm_ea   = hi == `CPM_OP_PMEM && ea
              && i_opcode[`CPM_F_T2] == `CPM_TAIL_PMEA;
  wire pm_aa   = hi == `CPM_OP_PMEM && !ea
              && i_opcode[`CPM_F_T2] == `CPM_TAIL_PMAA;
  wire pm      = pm_ea || pm_aa;
  wire memf    = ctl_mem || pm;
  // register side of a memory form: control reg or any register
  wire [5:0] rsel = pm ? i_opcode[`CPM_F_PMR] : crsel;

  // ========================================================
  // operand routing; the direction bit picks source or destination
  assign o_pmem     = pm;
  assign o_use_ea   = memf && ea;
  assign o_eimm     = o_use_ea && mode == `CPM_EA_IMM;
  assign o_need_ext = o_use_ea && (mode == `CPM_EA_ABS
                   || mode == `CPM_EA_IMM);
  assign o_src_imm  = ctl_imm || o_eimm;
  assign o_src_mem  = memf && w && !o_eimm;
  assign o_dst_mem  = memf && !w;
  assign o_src_sel  = ctl_reg ? (w ? mode : crsel) : rsel;
  assign o_dst_sel  = ctl_reg ? (w ? crsel : mode) : rsel;
  assign o_space    = pm ? cpm_pkg::SPC_P
                   : i_opcode[`CPM_F_SPC] ? cpm_pkg::SPC_Y
                   : cpm_pkg::SPC_X;
  // immediates cannot be stored to, nor used on program memory
  assign o_legal    = (memf || ctl_imm || ctl_reg)
                   && cr_ok(o_src_sel) && cr_ok(o_dst_sel)
                   && !(o_eimm && (!w || pm));
endmodule
`default_nettype wire
